// ==== rtl/fru_core.v ====
// command slice of a serial flash decoder: no-op, two-step software reset, unique-id read
// assumes the serial pins arrive asynchronously and are sampled on clk; the link clock
// is slow enough that clk sees every edge of it
// opcodes leave through a two-entry buffer to the rest of the decoder
//
// What this block does
// - no-op cancels a pending reset arm; its opcode is handed on through the buffer like any other
// - upper io lines are ignored; only serial input carries command bits
// - software reset needs an arm command followed by an execute command
// - a valid reset returns the decoder to standby
// - a valid reset clears the arm, op_reg and so to power-on defaults; the opcode buffer keeps its entries
// - execute is ignored unless a completed arm is still pending
// - any other command after arm discards the pending arm
// - reset during program or erase aborts that cycle
// - hold a read-only factory-set 128-bit unique identifier
// - uid read: opcode, four dummy bytes, then 128 id bits until deselect
// - opcode 4b selects the unique-id read
// - id bits leave on falling serial clock edges, msb first
// - command-only opcodes count only if deselect follows exactly eight bits
`timescale 1ns/1ps
`include "fru_regs.vh"
`default_nettype none
module fru_core #(
    parameter [127:0] UNIQUE_ID = `FRU_RESET_UID, // arbitrary value, set per die
    parameter RECOVERY_CYCLES = `FRU_RECOVERY_CYCLES
) (
    input wire clk,
    input wire nrst,
    input wire cs_n,
    input wire sclk,
    input wire si,
    input wire [2:0] upper_io_lines,
    input wire pe_busy,
    output reg so,
    output reg so_oe,
    output reg soft_reset_pulse,
    output reg pe_abort_pulse,
    output reg reset_arm_pending,
    output reg recovery_busy,
    output reg [7:0] opcode_out,
    output reg opcode_valid,
    input wire opcode_ready
);
// ****************************************
// input synchronisers
// ****************************************
reg [2:0] cs_sync_reg;
reg [2:0] sclk_sync_reg;
reg [1:0] si_sync_reg;
// two stages before use; third stage only for edge finding
// cs resets high and sclk low, their idle levels, so reset makes no false edge
// si shares the sclk delay so the bit taken on a rise is the one set up before it
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        cs_sync_reg <= 3'h7;
        sclk_sync_reg <= 3'h0;
        si_sync_reg <= 2'h0;
    end else begin
        cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
        sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
        si_sync_reg <= {si_sync_reg[0], si}; // upper io lines never sampled
    end
end
// synchronised levels and edges of the serial pins; an edge is seen two to
// three clk cycles after the pin moves, so each sclk half period must last
// at least four clk cycles
wire cs_low = ~cs_sync_reg[1];
wire cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];
wire sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
wire sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
// ****************************************
// frame decode
// ****************************************
// bit counter saturates at 255 so a long id read never wraps back to eight
// recovery counter is 16 bits wide; RECOVERY_CYCLES must fit in it
// op_reg keeps the last opcode until the eighth bit of the next frame or a soft reset
reg [7:0] shift_reg;
reg [7:0] bitcnt_reg;
reg [7:0] op_reg;
reg uid_mode_reg;
reg [6:0] uid_idx_reg;
reg [15:0] rec_cnt_reg;
reg [7:0] buf_data0_reg;
reg [7:0] buf_data1_reg;
reg [1:0] buf_count_reg;
// the id is a build-time parameter; there is no path that writes it
wire uid_bit = UNIQUE_ID[uid_idx_reg]; // fixed at build time, no write path
// the byte being completed by the current synced sclk rise
wire [7:0] next_byte = {shift_reg[6:0], si_sync_reg[1]};
// every frame of at least one byte hands its opcode on, refused during recovery or while the buffer is full
wire buf_push = cs_rise & ~recovery_busy & (bitcnt_reg >= `FRU_OPCODE_BITS)
    & (buf_count_reg != 2'h2);
// ****************************************
// decode helpers
// ****************************************
// a command-only frame counts only if it closed on exactly one opcode byte
function fru_exact_cmd;
    input [7:0] count;
    input [7:0] op;
    input [7:0] cmd;
    begin
        fru_exact_cmd = (count == `FRU_OPCODE_BITS) && (op == cmd);
    end
endfunction
// bit counting, opcode capture, reset sequencing
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        shift_reg <= 8'h00;
        bitcnt_reg <= 8'h00;
        op_reg <= 8'h00;
        uid_mode_reg <= 1'b0;
        uid_idx_reg <= 7'h7f;
        reset_arm_pending <= 1'b0;
        soft_reset_pulse <= 1'b0;
        pe_abort_pulse <= 1'b0;
        recovery_busy <= 1'b0;
        rec_cnt_reg <= 16'h0000;
        so <= 1'b0;
        so_oe <= 1'b0;
    end else begin
        soft_reset_pulse <= 1'b0;
        pe_abort_pulse <= 1'b0;
        if (recovery_busy) begin
            // commands ignored until recovery ends
            // a frame begun now is not counted and its bits are lost
            // busy drops one cycle after the counter has reached one
            if (rec_cnt_reg == 16'h0001)
                recovery_busy <= 1'b0;
            rec_cnt_reg <= rec_cnt_reg - 16'h0001;
            bitcnt_reg <= 8'h00;
        end else if (!cs_low) begin
            bitcnt_reg <= 8'h00;
            uid_mode_reg <= 1'b0;
            uid_idx_reg <= 7'h7f;
            so_oe <= 1'b0; // read ends on deselect
            // arm, execute and other commands act only here, on the synced cs rise that closes the frame; uid read starts at its eighth bit
            if (cs_rise && bitcnt_reg != 8'h00) begin
                if (fru_exact_cmd(bitcnt_reg, op_reg, `FRU_OP_RESET_EXEC)) begin
                    if (reset_arm_pending) begin
                        // arm, op_reg and so back to standby defaults; the opcode buffer keeps its entries
                        reset_arm_pending <= 1'b0;
                        soft_reset_pulse <= 1'b1;
                        // abort only matters if program or erase runs at this moment
                        pe_abort_pulse <= pe_busy;
                        recovery_busy <= 1'b1;
                        rec_cnt_reg <= RECOVERY_CYCLES[15:0];
                        op_reg <= 8'h00;
                        so <= 1'b0;
                    end
                end else if (fru_exact_cmd(bitcnt_reg, op_reg, `FRU_OP_RESET_ARM)) begin
                    reset_arm_pending <= 1'b1;
                end else begin
                    // cut or overlong frames land here too and also drop the arm
                    // no-op or any other command drops the arm
                    reset_arm_pending <= 1'b0;
                end
            end
        end else begin
            // each synced rise takes one bit of si, msb first
            if (sclk_rise) begin
                shift_reg <= next_byte;
                if (bitcnt_reg != 8'hff)
                    bitcnt_reg <= bitcnt_reg + 8'h01;
                if (bitcnt_reg == 8'h07) begin
                    op_reg <= next_byte;
                    uid_mode_reg <= (next_byte == `FRU_OP_UID_READ);
                end
            end
            if (sclk_fall && uid_mode_reg && bitcnt_reg >= `FRU_UID_START_BIT) begin
                // after opcode and four dummy bytes, msb first, wraps
                // the bit leaves a few clk cycles after the pin edge, well before the next rise
                so <= uid_bit;
                so_oe <= 1'b1;
                uid_idx_reg <= uid_idx_reg - 7'h01;
            end
        end
    end
end
// ****************************************
// opcode hand-off buffer
// ****************************************
// two entries so a consumer stalled over up to two frames loses no opcode
// a push into a full buffer is dropped; frames are far too slow to fill it
// the output stage shows the head and, on a pop, already the next entry
// pop without push: the second entry moves to the head
// push and pop together with one entry: the new word is the head after one idle cycle
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        buf_data0_reg <= 8'h00;
        buf_data1_reg <= 8'h00;
        buf_count_reg <= 2'h0;
        opcode_out <= 8'h00;
        opcode_valid <= 1'b0;
    end else begin
        if (buf_push && !(opcode_valid && opcode_ready)) begin
            if (buf_count_reg == 2'h0)
                buf_data0_reg <= op_reg;
            else
                buf_data1_reg <= op_reg;
            buf_count_reg <= buf_count_reg + 2'h1;
        end else if (!buf_push && opcode_valid && opcode_ready) begin
            buf_data0_reg <= buf_data1_reg;
            buf_count_reg <= buf_count_reg - 2'h1;
        end else if (buf_push) begin
            if (buf_count_reg == 2'h1)
                buf_data0_reg <= op_reg;
            else
                buf_data0_reg <= buf_data1_reg;
            if (buf_count_reg == 2'h2)
                buf_data1_reg <= op_reg;
        end
        opcode_valid <= 1'b0;
        opcode_out <= 8'h00;
        if (buf_count_reg != 2'h0 && !(opcode_valid && opcode_ready && buf_count_reg == 2'h1)) begin
            opcode_valid <= 1'b1;
            opcode_out <= (opcode_valid && opcode_ready) ? buf_data1_reg : buf_data0_reg;
        end
    end
end
endmodule
`default_nettype wire

// ==== rtl/fru_regs.vh ====
// constants for the reset and unique-id command slice of the serial flash decoder
// assumes inclusion by bare name from the design file
`ifndef FRU_REGS_VH
`define FRU_REGS_VH
// ****************************************
// opcodes
// ****************************************
`define FRU_OP_NOP 8'h00
`define FRU_OP_RESET_ARM 8'h66
`define FRU_OP_RESET_EXEC 8'h99
`define FRU_OP_UID_READ 8'h4b
// ****************************************
// frame layout and timing
// ****************************************
`define FRU_OPCODE_BITS 8'h08
`define FRU_UID_START_BIT 8'h28
`define FRU_UID_BITS 8'h80
`define FRU_RECOVERY_NS 12000
`define FRU_CLK_PERIOD_NS 5
`define FRU_RECOVERY_CYCLES ((`FRU_RECOVERY_NS + `FRU_CLK_PERIOD_NS - 1) / `FRU_CLK_PERIOD_NS)
`define FRU_RESET_UID 128'h0123456789abcdeffedcba9876543210
`endif

// ==== verification/fru_monitor.sv ====
// checker for the command slice; sees only the core's ports
// assumes one clock domain with async active-low reset
`timescale 1ns/1ps
`default_nettype none
module fru_monitor (
    input wire clk,
    input wire nrst,
    input wire cs_n,
    input wire so_oe,
    input wire soft_reset_pulse,
    input wire pe_abort_pulse,
    input wire reset_arm_pending,
    input wire recovery_busy,
    input wire [7:0] opcode_out,
    input wire opcode_valid,
    input wire opcode_ready
);
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_abort_with_reset: assert property (pe_abort_pulse |-> soft_reset_pulse)
        else $error("abort without reset");
    chk_reset_one_cycle: assert property (soft_reset_pulse |=> !soft_reset_pulse)
        else $error("reset pulse too long");
    chk_reset_needs_arm: assert property ($rose(soft_reset_pulse) |-> $past(reset_arm_pending))
        else $error("reset without arm");
    chk_reset_clears_arm: assert property (soft_reset_pulse |=> !reset_arm_pending)
        else $error("arm kept over reset");
    chk_recovery_starts: assert property (soft_reset_pulse |-> ##[0:2] recovery_busy)
        else $error("no recovery");
    chk_no_reset_recov: assert property (recovery_busy && $past(recovery_busy) |-> !soft_reset_pulse)
        else $error("reset during recovery");
    chk_oe_deselect: assert property ($rose(cs_n) |-> ##[1:4] !so_oe)
        else $error("output kept after deselect");
    chk_quiet_opcode: assert property ($fell(cs_n) |=> !so_oe [*8])
        else $error("output during opcode");
    chk_opcode_hold: assert property (opcode_valid && !opcode_ready |=> opcode_valid && $stable(opcode_out))
        else $error("opcode lost in stall");
    cov_reset: cover property (soft_reset_pulse);
    cov_abort: cover property (pe_abort_pulse);
    cov_uid: cover property (so_oe);
endmodule
bind fru_core fru_monitor fru_monitor_i (.clk(clk), .nrst(nrst), .cs_n(cs_n), .so_oe(so_oe),
    .soft_reset_pulse(soft_reset_pulse), .pe_abort_pulse(pe_abort_pulse),
    .reset_arm_pending(reset_arm_pending), .recovery_busy(recovery_busy),
    .opcode_out(opcode_out), .opcode_valid(opcode_valid), .opcode_ready(opcode_ready));
`default_nettype wire

// ==== verification/fru_host.sv ====
// host spi master model; clock idles low between frames
// assumes the device answers within a half period of 80 ns
`timescale 1ns/1ps
`default_nettype none
module fru_host (
    output logic cs_n,
    output logic sclk,
    output logic si,
    input wire logic so
);
    logic [127:0] rx;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    // one frame msb first, so captured on every rise; deselect on a bit boundary
    task automatic xfer(input logic [167:0] d, input int n);
        cs_n = 1'b0;
        #80;
        for (int i = 0; i < n; i++) begin
            si = d[167 - i];
            #80 sclk = 1'b1;
            rx = {rx[126:0], so};
            #80 sclk = 1'b0;
        end
        si = ~si; // released data line must not look held
        #80 cs_n = 1'b1;
        #400;
    endtask
endmodule
`default_nettype wire

// ==== verification/fru_core_test.sv ====
// self-checking bench: frame model with integers against the core
// assumes the host model drives the serial pins
`timescale 1ns/1ps
`default_nettype none
module fru_core_test;
    localparam [127:0] UID = 128'h5a1e_c0de_7788_9911_2468_ace0_1357_9bdf; // arbitrary value
    logic clk = 1'b0, nrst = 1'b0, pe_busy = 1'b0, opcode_ready = 1'b0;
    logic [2:0] uio = 3'h0;
    logic [15:0] lf = 16'hbf81;
    logic [7:0] last_op = 8'h00, opcode_out;
    wire cs_n, sclk, si, so, soft_reset_pulse, pe_abort_pulse, reset_arm_pending, opcode_valid;
    int bad_count = 0, tests_run = 0, rst_seen = 0, abort_seen = 0, exp_rst = 0, arm = 0;
    logic [7:0] exp_q[$];
    fru_core #(.UNIQUE_ID(UID), .RECOVERY_CYCLES(20)) fru_core_i (.clk(clk), .nrst(nrst),
        .cs_n(cs_n), .sclk(sclk), .si(si), .upper_io_lines(uio), .pe_busy(pe_busy), .so(so),
        .so_oe(), .soft_reset_pulse(soft_reset_pulse), .pe_abort_pulse(pe_abort_pulse),
        .reset_arm_pending(reset_arm_pending), .recovery_busy(), .opcode_out(opcode_out),
        .opcode_valid(opcode_valid), .opcode_ready(opcode_ready));
    fru_host fru_host_i (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so));
    always #2.5 clk = ~clk;
    // sixteen-bit lfsr step, taps at bits 15 13 12 10
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // random stalls and noise on the upper io lines
    always @(posedge clk) begin
        #1;
        lf = lfsr_next(lf);
        opcode_ready = lf[0] | lf[1];
        uio = lf[4:2];
    end
    always @(posedge clk) begin
        if (soft_reset_pulse === 1'b1) rst_seen++;
        if (pe_abort_pulse === 1'b1) abort_seen++;
        // every opcode handed on must be the next one the model expects
        if (opcode_valid === 1'b1 && opcode_ready === 1'b1) begin
            last_op <= opcode_out;
            check(exp_q.size() != 0, 1, "opcode expected");
            if (exp_q.size() != 0) check(opcode_out, exp_q.pop_front(), "opcode out");
        end
    end
    task automatic check(input logic [127:0] seen, exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // frame plus the reference arm model
    task automatic frame(input logic [7:0] op, input int n);
        if (n >= 8) exp_q.push_back(op);
        fru_host_i.xfer({op, 160'h0}, n);
        if (n == 8 && op == 8'h99 && arm == 1) exp_rst++;
        arm = (n == 8 && op == 8'h66);
    endtask
    task automatic close_out;
        $display("tests %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #200000 bad_count++;
        close_out;
    end
    initial begin
        repeat (20) @(posedge clk);
        #1 nrst = 1'b1;
        pe_busy = 1'b1;
        frame(8'h66, 8);
        check(reset_arm_pending, 1, "arm");
        frame(8'h99, 8);
        pe_busy = 1'b0;
        check(rst_seen, exp_rst, "reset");
        check(abort_seen, 1, "abort");
        check(reset_arm_pending, 0, "arm clear");
        $display("test reset done");
        frame(8'h66, 8);
        frame(8'h00, 8);
        frame(8'h99, 8);
        frame(8'h99, 8);
        frame(8'h66, 8);
        frame(8'h99, 9);
        check(rst_seen, exp_rst, "cancel");
        $display("test cancel done");
        frame(8'h66, 8);
        frame(8'h4b, 168);
        check(fru_host_i.rx, UID, "uid");
        frame(8'h99, 8);
        check(last_op, 8'h99, "opcode");
        check(rst_seen, exp_rst, "uid cancel");
        frame(8'h66, 8);
        frame(8'h99, 8);
        check(rst_seen, exp_rst, "second reset");
        check(abort_seen, 1, "no abort");
        check(exp_q.size(), 0, "opcodes left");
        $display("test uid done");
        close_out;
    end
endmodule
`default_nettype wire
